// ==== inc/pin_control_pkg.sv ====
// Purpose: shared constants for the two-port pin control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   offsets are byte addresses of aligned words

package pin_control_pkg;

   // ***********************************************************
   // port widths
   // ***********************************************************
   localparam int SMALL_W = 4;
   localparam int WIDE_W  = 8;
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 8;

   // ***********************************************************
   // register byte offsets
   // ***********************************************************
   localparam logic [ADDR_W-1:0] OFS_SMALL_PULLUP = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SMALL_SLEW   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SMALL_DRIVE  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_WIDE_DATA    = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_WIDE_DIR     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_WIDE_PULLUP  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_WIDE_SLEW    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_WIDE_DRIVE   = 8'h1c;

   // ***********************************************************
   // field positions and reset values
   // ***********************************************************
   localparam int SMALL_LSB = 0;
   localparam int WIDE_LSB  = 0;
   localparam logic [SMALL_W-1:0] RST_SMALL = 4'h0;
   localparam logic [WIDE_W-1:0]  RST_WIDE  = 8'h00;

   // ***********************************************************
   // bus response codes
   // ***********************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pin_control_pkg

// ==== logic/port_d_e_pin_control.sv ====
// Purpose: register-controlled pad logic for a 4-bit and an 8-bit port
// Assumes: the 4-bit port direction comes from logic on the same clock
// Notes:   pad outputs are registered; register writes reach them at the
//          same edge that stores the register value

`timescale 1ns/1ps
`default_nettype none

// Function
// - A small-port pin's pullup is on when its pullup bit is 1 and off at 0.
// - A small-port pin driven as output keeps its pullup off whatever the bit.
// - Small-port slew bits 3:0 enable output slew limiting when set.
// - A small-port slew bit has no effect while its pin is an input.
// - Small-port drive bits 3:0 select low drive at 0 and high drive at 1.
// - Reading the wide data register returns the pin level for input pins.
// - Reading the wide data register returns the latch for output pins.
// - A wide data write updates every latch bit whatever the direction.
// - Each wide-port output pin is driven with its latched value.
// - Reset clears the wide latch and leaves all pins undriven, pullups off.
// - A wide direction bit at 0 means input and pin reads, 1 means output.
// - Wide pullup bits enable pullups, forced off on output pins.
// - Wide slew bits enable slew limiting, without effect on input pins.
// - Wide drive bits select low drive at 0 and high drive at 1.
module port_d_e_pin_control
   import pin_control_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              srst,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   // axi4-lite write data
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // axi4-lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   // axi4-lite read data
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // small port pads
   input  wire logic [SMALL_W-1:0] smallPortDir,
   output logic [SMALL_W-1:0]      smallPullupEn,
   output logic [SMALL_W-1:0]      smallSlewEn,
   output logic [SMALL_W-1:0]      smallDriveHigh,
   // wide port pads
   input  wire logic [WIDE_W-1:0]  widePinIn,
   output logic [WIDE_W-1:0]       widePinOut,
   output logic [WIDE_W-1:0]       widePinOe,
   output logic [WIDE_W-1:0]       widePullupEn,
   output logic [WIDE_W-1:0]       wideSlewEn,
   output logic [WIDE_W-1:0]       wideDriveHigh
);

   // ***********************************************************
   // declarations
   // ***********************************************************
   // write channel holding state
   logic              awHeld_r,  awHeld_nxt;
   logic [ADDR_W-1:0] awAddr_r,  awAddr_nxt;
   logic              wHeld_r,   wHeld_nxt;
   logic [DATA_W-1:0] wData_r,   wData_nxt;
   logic [3:0]        wStrb_r,   wStrb_nxt;
   logic              awready_r, awready_nxt;
   logic              wready_r,  wready_nxt;
   logic              bvalid_r,  bvalid_nxt;
   logic [1:0]        bresp_r,   bresp_nxt;
   logic              doWrite;
   logic              laneZero;
   logic              wrHit;

   // read channel state
   logic              arready_r, arready_nxt;
   logic              rvalid_r,  rvalid_nxt;
   logic [DATA_W-1:0] rdata_r,   rdata_nxt;
   logic [1:0]        rresp_r,   rresp_nxt;
   logic              arTake;
   logic [WIDE_W-1:0] rdByte;
   logic              rdHit;

   // software registers
   logic [SMALL_W-1:0] smallPu_r,  smallPu_nxt;
   logic [SMALL_W-1:0] smallSe_r,  smallSe_nxt;
   logic [SMALL_W-1:0] smallDs_r,  smallDs_nxt;
   logic [WIDE_W-1:0]  wideDat_r,  wideDat_nxt;
   logic [WIDE_W-1:0]  wideDir_r,  wideDir_nxt;
   logic [WIDE_W-1:0]  widePu_r,   widePu_nxt;
   logic [WIDE_W-1:0]  wideSe_r,   wideSe_nxt;
   logic [WIDE_W-1:0]  wideDs_r,   wideDs_nxt;

   // pin synchroniser
   logic [WIDE_W-1:0]  pinMeta_r;
   logic [WIDE_W-1:0]  pinSync_r;

   // registered pad controls
   logic [SMALL_W-1:0] smallPuPad_r, smallPuPad_nxt;
   logic [SMALL_W-1:0] smallSePad_r, smallSePad_nxt;
   logic [SMALL_W-1:0] smallDsPad_r, smallDsPad_nxt;
   logic [WIDE_W-1:0]  wideOut_r,    wideOut_nxt;
   logic [WIDE_W-1:0]  wideOe_r,     wideOe_nxt;
   logic [WIDE_W-1:0]  widePuPad_r,  widePuPad_nxt;
   logic [WIDE_W-1:0]  wideSePad_r,  wideSePad_nxt;
   logic [WIDE_W-1:0]  wideDsPad_r,  wideDsPad_nxt;

   // ***********************************************************
   // write channel
   // ***********************************************************
   // address and data are caught independently and held until both
   // are present; a pending response blocks the next write so that
   // at most one answer is ever outstanding
   always_comb
   begin
      doWrite     = awHeld_r && wHeld_r && !bvalid_r;
      awHeld_nxt  = awHeld_r;
      awAddr_nxt  = awAddr_r;
      wHeld_nxt   = wHeld_r;
      wData_nxt   = wData_r;
      wStrb_nxt   = wStrb_r;
      if (awvalid && awready_r)
      begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = awaddr;
      end
      else if (doWrite)
      begin
         awHeld_nxt = 1'b0;
      end
      if (wvalid && wready_r)
      begin
         wHeld_nxt = 1'b1;
         wData_nxt = wdata;
         wStrb_nxt = wstrb;
      end
      else if (doWrite)
      begin
         wHeld_nxt = 1'b0;
      end
      awready_nxt = !awHeld_nxt;
      wready_nxt  = !wHeld_nxt;
      bvalid_nxt  = doWrite || (bvalid_r && !bready);
      bresp_nxt   = bresp_r;
      if (doWrite)
      begin
         bresp_nxt = wrHit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // address decode for writes; only byte lane zero carries data
   always_comb
   begin
      laneZero = wStrb_r[0];
      case (awAddr_r)
         OFS_SMALL_PULLUP, OFS_SMALL_SLEW, OFS_SMALL_DRIVE,
         OFS_WIDE_DATA, OFS_WIDE_DIR, OFS_WIDE_PULLUP,
         OFS_WIDE_SLEW, OFS_WIDE_DRIVE:
            wrHit = 1'b1;
         default:
            wrHit = 1'b0;
      endcase
   end

   // ***********************************************************
   // register file
   // ***********************************************************
   // upper small-port bits are not stored: whatever software puts
   // there is dropped, and they read back as zero
   always_comb
   begin
      smallPu_nxt = smallPu_r;
      smallSe_nxt = smallSe_r;
      smallDs_nxt = smallDs_r;
      wideDat_nxt = wideDat_r;
      wideDir_nxt = wideDir_r;
      widePu_nxt  = widePu_r;
      wideSe_nxt  = wideSe_r;
      wideDs_nxt  = wideDs_r;
      if (doWrite && laneZero)
      begin
         case (awAddr_r)
            OFS_SMALL_PULLUP: smallPu_nxt = wData_r[SMALL_LSB +: SMALL_W];
            OFS_SMALL_SLEW:   smallSe_nxt = wData_r[SMALL_LSB +: SMALL_W];
            OFS_SMALL_DRIVE:  smallDs_nxt = wData_r[SMALL_LSB +: SMALL_W];
            OFS_WIDE_DATA:    wideDat_nxt = wData_r[WIDE_LSB +: WIDE_W];
            OFS_WIDE_DIR:     wideDir_nxt = wData_r[WIDE_LSB +: WIDE_W];
            OFS_WIDE_PULLUP:  widePu_nxt  = wData_r[WIDE_LSB +: WIDE_W];
            OFS_WIDE_SLEW:    wideSe_nxt  = wData_r[WIDE_LSB +: WIDE_W];
            OFS_WIDE_DRIVE:   wideDs_nxt  = wData_r[WIDE_LSB +: WIDE_W];
            default:          smallPu_nxt = smallPu_r;
         endcase
      end
   end

   // ***********************************************************
   // read channel
   // ***********************************************************
   // read data is captured at the address handshake, so a pin that
   // moves later does not alter an answer already waiting
   always_comb
   begin
      arTake      = arvalid && arready_r;
      rvalid_nxt  = arTake || (rvalid_r && !rready);
      arready_nxt = !rvalid_nxt;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      rdByte      = RST_WIDE;
      rdHit       = 1'b1;
      case (araddr)
         OFS_SMALL_PULLUP: rdByte[SMALL_W-1:0] = smallPu_r;
         OFS_SMALL_SLEW:   rdByte[SMALL_W-1:0] = smallSe_r;
         OFS_SMALL_DRIVE:  rdByte[SMALL_W-1:0] = smallDs_r;
         // output pins read the latch, input pins the pin level
         OFS_WIDE_DATA:    rdByte = (wideDir_r & wideDat_r)
                                  | (~wideDir_r & pinSync_r);
         OFS_WIDE_DIR:     rdByte = wideDir_r;
         OFS_WIDE_PULLUP:  rdByte = widePu_r;
         OFS_WIDE_SLEW:    rdByte = wideSe_r;
         OFS_WIDE_DRIVE:   rdByte = wideDs_r;
         default:          rdHit  = 1'b0;
      endcase
      if (arTake)
      begin
         rdata_nxt = {{(DATA_W-WIDE_W){1'b0}}, rdByte};
         rresp_nxt = rdHit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ***********************************************************
   // pad controls
   // ***********************************************************
   // computed from the next register values so that a write shows on
   // the pads at the very edge that stores it; the small-port
   // direction arrives from elsewhere and so lags by one cycle
   always_comb
   begin
      smallPuPad_nxt = smallPu_nxt & ~smallPortDir;
      smallSePad_nxt = smallSe_nxt & smallPortDir;
      smallDsPad_nxt = smallDs_nxt;
      wideOut_nxt    = wideDat_nxt;
      wideOe_nxt     = wideDir_nxt;
      widePuPad_nxt  = widePu_nxt & ~wideDir_nxt;
      wideSePad_nxt  = wideSe_nxt & wideDir_nxt;
      wideDsPad_nxt  = wideDs_nxt;
   end

   // ***********************************************************
   // flip-flops
   // ***********************************************************
   // reset leaves every pin an undriven input with pullups off
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         awHeld_r     <= 1'b0;
         awAddr_r     <= '0;
         wHeld_r      <= 1'b0;
         wData_r      <= '0;
         wStrb_r      <= '0;
         awready_r    <= 1'b1;
         wready_r     <= 1'b1;
         bvalid_r     <= 1'b0;
         bresp_r      <= RESP_OKAY;
         arready_r    <= 1'b1;
         rvalid_r     <= 1'b0;
         rdata_r      <= '0;
         rresp_r      <= RESP_OKAY;
         smallPu_r    <= RST_SMALL;
         smallSe_r    <= RST_SMALL;
         smallDs_r    <= RST_SMALL;
         wideDat_r    <= RST_WIDE;
         wideDir_r    <= RST_WIDE;
         widePu_r     <= RST_WIDE;
         wideSe_r     <= RST_WIDE;
         wideDs_r     <= RST_WIDE;
         smallPuPad_r <= RST_SMALL;
         smallSePad_r <= RST_SMALL;
         smallDsPad_r <= RST_SMALL;
         wideOut_r    <= RST_WIDE;
         wideOe_r     <= RST_WIDE;
         widePuPad_r  <= RST_WIDE;
         wideSePad_r  <= RST_WIDE;
         wideDsPad_r  <= RST_WIDE;
      end
      else
      begin
         awHeld_r     <= awHeld_nxt;
         awAddr_r     <= awAddr_nxt;
         wHeld_r      <= wHeld_nxt;
         wData_r      <= wData_nxt;
         wStrb_r      <= wStrb_nxt;
         awready_r    <= awready_nxt;
         wready_r     <= wready_nxt;
         bvalid_r     <= bvalid_nxt;
         bresp_r      <= bresp_nxt;
         arready_r    <= arready_nxt;
         rvalid_r     <= rvalid_nxt;
         rdata_r      <= rdata_nxt;
         rresp_r      <= rresp_nxt;
         smallPu_r    <= smallPu_nxt;
         smallSe_r    <= smallSe_nxt;
         smallDs_r    <= smallDs_nxt;
         wideDat_r    <= wideDat_nxt;
         wideDir_r    <= wideDir_nxt;
         widePu_r     <= widePu_nxt;
         wideSe_r     <= wideSe_nxt;
         wideDs_r     <= wideDs_nxt;
         smallPuPad_r <= smallPuPad_nxt;
         smallSePad_r <= smallSePad_nxt;
         smallDsPad_r <= smallDsPad_nxt;
         wideOut_r    <= wideOut_nxt;
         wideOe_r     <= wideOe_nxt;
         widePuPad_r  <= widePuPad_nxt;
         wideSePad_r  <= wideSePad_nxt;
         wideDsPad_r  <= wideDsPad_nxt;
      end
   end

   // two-stage synchroniser on the wide pins; only the second stage
   // is looked at, so read data lags the pin by two cycles
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pinMeta_r <= RST_WIDE;
         pinSync_r <= RST_WIDE;
      end
      else
      begin
         pinMeta_r <= widePinIn;
         pinSync_r <= pinMeta_r;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign awready        = awready_r;
   assign wready         = wready_r;
   assign bvalid         = bvalid_r;
   assign bresp          = bresp_r;
   assign arready        = arready_r;
   assign rvalid         = rvalid_r;
   assign rdata          = rdata_r;
   assign rresp          = rresp_r;
   assign smallPullupEn  = smallPuPad_r;
   assign smallSlewEn    = smallSePad_r;
   assign smallDriveHigh = smallDsPad_r;
   assign widePinOut     = wideOut_r;
   assign widePinOe      = wideOe_r;
   assign widePullupEn   = widePuPad_r;
   assign wideSlewEn     = wideSePad_r;
   assign wideDriveHigh  = wideDsPad_r;

endmodule // port_d_e_pin_control

`default_nettype wire

// ==== tb/board_pins_model.sv ====
// Purpose: board circuitry seen at the wide port pins
// Assumes: the bench enables board drivers only where it wants them
// Notes:   a pin nobody holds toggles, so a stale read cannot pass
`timescale 1ns/1ps
`default_nettype none
module board_pins_model
   import pin_control_pkg::*;
(
   // clock
   input  wire logic              ref_clk,
   // pad side of the block
   input  wire logic [WIDE_W-1:0] widePinOut,
   input  wire logic [WIDE_W-1:0] widePinOe,
   input  wire logic [WIDE_W-1:0] widePullupEn,
   // board drivers
   input  wire logic [WIDE_W-1:0] extVal,
   input  wire logic [WIDE_W-1:0] extEn,
   // level back into the block
   output logic [WIDE_W-1:0]      widePinIn
);
   // ***********************************************************
   // wire resolution
   // ***********************************************************
   logic [WIDE_W-1:0] floatLevel_r = '0;
   // floating level changes every cycle
   always_ff @(posedge ref_clk)
      floatLevel_r <= ~floatLevel_r;
   // block driver first, then board, then pullup or float
   assign widePinIn = (widePinOe & widePinOut)
      | (~widePinOe & extEn & extVal)
      | (~widePinOe & ~extEn & (widePullupEn | floatLevel_r));
endmodule // board_pins_model
`default_nettype wire

// ==== tb/pin_control_sva.sv ====
// Purpose: bus and pad checks for the two-port pin control block
// Assumes: bound to the top module, single clock domain
// Notes:   small-port pads follow the direction input one edge late
`timescale 1ns/1ps
`default_nettype none
module pin_control_sva
   import pin_control_pkg::*;
(
   // clock and reset
   input wire logic                ref_clk,
   input wire logic                srst,
   // write channels
   input wire logic [ADDR_W-1:0]   awaddr,
   input wire logic                awvalid,
   input wire logic                awready,
   input wire logic [DATA_W-1:0]   wdata,
   input wire logic [3:0]          wstrb,
   input wire logic                wvalid,
   input wire logic                wready,
   input wire logic [1:0]          bresp,
   input wire logic                bvalid,
   input wire logic                bready,
   // read channels
   input wire logic [ADDR_W-1:0]   araddr,
   input wire logic                arvalid,
   input wire logic                arready,
   input wire logic [DATA_W-1:0]   rdata,
   input wire logic [1:0]          rresp,
   input wire logic                rvalid,
   input wire logic                rready,
   // pads
   input wire logic [SMALL_W-1:0]  smallPortDir,
   input wire logic [SMALL_W-1:0]  smallPullupEn,
   input wire logic [SMALL_W-1:0]  smallSlewEn,
   input wire logic [SMALL_W-1:0]  smallDriveHigh,
   input wire logic [WIDE_W-1:0]   widePinIn,
   input wire logic [WIDE_W-1:0]   widePinOut,
   input wire logic [WIDE_W-1:0]   widePinOe,
   input wire logic [WIDE_W-1:0]   widePullupEn,
   input wire logic [WIDE_W-1:0]   wideSlewEn,
   input wire logic [WIDE_W-1:0]   wideDriveHigh
);
   // ***********************************************************
   // sequences and assertions
   // ***********************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // both write channels taken together while no answer is pending
   sequence wrTake;
      awvalid && awready && wvalid && wready && !bvalid;
   endsequence
   sequence dirWrite;
      wrTake ##0 (awaddr == OFS_WIDE_DIR && wstrb[0]);
   endsequence
   wr_answer_a: assert property (wrTake |-> ##1 !bvalid ##1 bvalid)
      else $error("write answer late or early");
   wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   dir_write_a: assert property (dirWrite |-> ##2
      widePinOe == $past(wdata[WIDE_W-1:0], 2))
      else $error("direction write not on pads");
   rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer missing");
   rd_hold_a: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped");
   rd_unmapped_a: assert property (arvalid && arready &&
      araddr > OFS_WIDE_DRIVE |=> rresp == RESP_SLVERR && rdata == '0)
      else $error("unmapped read not refused");
   small_pull_a: assert property (
      (smallPullupEn & $past(smallPortDir)) == '0)
      else $error("small pullup on an output");
   small_slew_a: assert property (
      (smallSlewEn & ~$past(smallPortDir)) == '0)
      else $error("small slew on an input");
   wide_pull_a: assert property ((widePullupEn & widePinOe) == '0)
      else $error("wide pullup on an output");
   wide_slew_a: assert property ((wideSlewEn & ~widePinOe) == '0)
      else $error("wide slew on an input");
   reset_pads_a: assert property ($fell(srst) |-> widePinOe == '0 &&
      widePinOut == '0 && widePullupEn == '0 && smallPullupEn == '0)
      else $error("pads not idle after reset");
endmodule // pin_control_sva

bind port_d_e_pin_control pin_control_sva u_pin_control_sva (.*);
`default_nettype wire

// ==== tb/port_d_e_pin_control_bench.sv ====
// Purpose: random register traffic against a behavioural register model
// Assumes: board drivers leave a pin open only where its pullup is on
// Notes:   pins are read four cycles after change to pass the synchroniser
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
   begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module port_d_e_pin_control_bench;
   import pin_control_pkg::*;
   // ***********************************************************
   // stimulus, model and instances
   // ***********************************************************
   logic                ref_clk = 1'b0;
   logic                srst = 1'b1;
   logic [ADDR_W-1:0]   awaddr = '0, araddr = '0;
   logic [DATA_W-1:0]   wdata = '0;
   logic [3:0]          wstrb = '0;
   logic                awvalid = 0, wvalid = 0, bready = 0;
   logic                arvalid = 0, rready = 0;
   logic [1:0]          bresp, rresp;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [DATA_W-1:0]   rdata;
   logic [SMALL_W-1:0]  smallPortDir = '0;
   logic [SMALL_W-1:0]  smallPullupEn, smallSlewEn, smallDriveHigh;
   logic [WIDE_W-1:0]   extVal = '0, extEn = '1, widePinIn, widePinOut;
   logic [WIDE_W-1:0]   widePinOe, widePullupEn, wideSlewEn, wideDriveHigh;
   logic [7:0]          m [8];
   int                  error_cnt = 0, comparisons = 0, seed;
   port_d_e_pin_control u_port_d_e_pin_control (.*);
   board_pins_model u_board_pins_model (.*);
   always #5 ref_clk = ~ref_clk;
   // expected read value from the model and the board drivers
   function automatic logic [31:0] expv(logic [7:0] a);
      logic [7:0] pin = (extEn & extVal) | ~extEn;
      if (a > OFS_WIDE_DRIVE)
         return '0;
      if (a == OFS_WIDE_DATA)
         return {24'h0, (m[4] & m[3]) | (~m[4] & pin)};
      return {24'h0, m[a >> 2]};
   endfunction
   // write with a random first bready, raised once both channels are taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      bit aw = 0;
      bit w = 0;
      bit ok = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'($random(seed));
      for (int n = 0; n < 50; n++)
      begin
         @(posedge ref_clk);
         if (aw && w && bready && bvalid === 1'b1)
         begin
            ok = 1'b1;
            break;
         end
         aw |= (awready === 1'b1);
         w |= (wready === 1'b1);
         if (aw)
            awvalid <= 1'b0;
         if (w)
            wvalid <= 1'b0;
         if (aw && w)
            bready <= 1'b1;
      end
      bready <= 1'b0;
      // a write that never answers must not pass on a stale response
      `CHK("bdone", 1'b1, ok)
      `CHK("bresp", a > OFS_WIDE_DRIVE ? RESP_SLVERR : RESP_OKAY, bresp)
      if (a <= OFS_WIDE_DRIVE && s[0])
         m[a >> 2] = d[7:0];
   endtask
   // read with a random first rready, raised once the address is taken
   task automatic chk_rd(input logic [7:0] a);
      bit tk = 0;
      bit ok = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'($random(seed));
      for (int n = 0; n < 50; n++)
      begin
         @(posedge ref_clk);
         if (tk && rready && rvalid === 1'b1)
         begin
            ok = 1'b1;
            break;
         end
         tk |= (arready === 1'b1);
         if (tk)
            arvalid <= 1'b0;
         if (tk)
            rready <= 1'b1;
      end
      rready <= 1'b0;
      `CHK("rdone", 1'b1, ok)
      `CHK("rdata", expv(a), rdata)
      `CHK("rresp", a > OFS_WIDE_DRIVE ? RESP_SLVERR : RESP_OKAY, rresp)
   endtask
   // pad outputs against the model
   task automatic padchk;
      `CHK("spu", m[0][3:0] & ~smallPortDir, smallPullupEn)
      `CHK("sse", m[1][3:0] & smallPortDir, smallSlewEn)
      `CHK("sds", m[2][3:0], smallDriveHigh)
      `CHK("out", m[3], widePinOut)
      `CHK("oe", m[4], widePinOe)
      `CHK("wpu", m[5] & ~m[4], widePullupEn)
      `CHK("wse", m[6] & m[4], wideSlewEn)
      `CHK("wds", m[7], wideDriveHigh)
   endtask
   // reset, then check every register and pad at its reset value
   task automatic do_reset;
      srst <= 1'b1;
      // reset turns pullups off, so the board must hold every pin
      extEn <= '1;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      foreach (m[i])
         m[i] = '0;
      for (int k = 0; k < 10; k++)
         chk_rd(k * 4);
      padchk();
   endtask
   task automatic conclude;
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #200000;
      error_cnt++;
      conclude();
   end
   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial
   begin
      logic [7:0] a;
      logic [31:0] d;
      logic [3:0] s;
      seed = 32'h8c39;
      do_reset();
      for (int it = 0; it < 120; it++)
      begin
         if (it == 60)
            do_reset();
         a = 8'({$random(seed)} % 10 * 4);
         d = $random(seed);
         if (a < OFS_WIDE_DATA)
            d[7:4] = 4'h0;
         s = 4'($random(seed));
         s[0] = (it % 8 != 3);
         wr(a, d, s);
         smallPortDir <= 4'($random(seed));
         extVal <= 8'($random(seed));
         extEn <= 8'($random(seed)) | ~m[5];
         repeat (4) @(posedge ref_clk);
         chk_rd(a);
         chk_rd(OFS_WIDE_DATA);
         padchk();
      end
      conclude();
   end
endmodule // port_d_e_pin_control_bench
`default_nettype wire
